// *** src/otdu_pkg.sv ***
// Constants and types for the output time delay unit
// Functional notes
// - Delays span zero to 5.46 minutes, 5 ms steps
// - Each switch: on, off, no-target delay
// - Reset defaults: on/off zero, no-target sixty seconds
// - Timer starts when trigger condition first appears
// - Trigger loss clears count to zero
// - Action only after trigger held full period
// - One analog no-target delay, default zero
// - Expiry forces analog outputs to chosen value
// - Separate no-target choices for current and voltage
// - Analog delay retriggers; target return restores normal
// - Separate no-sync delay, default zero
package otdu_pkg;
  // Clock and tick timing
  localparam int CLK_MHZ      = 250;
  localparam int TICK_US      = 5000;
  localparam int TICK_CYCLES  = CLK_MHZ * TICK_US;
  localparam int DIV_W        = 21;
  // Delay word, 65535 ticks of 5 ms is 5.46 minutes
  localparam int DLY_W        = 16;
  localparam int NUM_SW       = 2;
  localparam int NUM_TMR      = 3 * NUM_SW + 2;
  // Timer slots
  localparam int T_ANA        = 3 * NUM_SW;
  localparam int T_SYNC       = 3 * NUM_SW + 1;
  // Reset values, in milliseconds and in ticks
  localparam int DEF_ONOFF_MS = 0;
  localparam int DEF_NT_MS    = 60000;
  localparam int DEF_ANA_MS   = 0;
  localparam int DEF_SYNC_MS  = 0;
  localparam logic [DLY_W-1:0] DEF_ONOFF = DLY_W'(DEF_ONOFF_MS / 5);
  localparam logic [DLY_W-1:0] DEF_NT    = DLY_W'(DEF_NT_MS / 5);
  localparam logic [DLY_W-1:0] DEF_ANA   = DLY_W'(DEF_ANA_MS / 5);
  localparam logic [DLY_W-1:0] DEF_SYNC  = DLY_W'(DEF_SYNC_MS / 5);
  // Register map, word index times four
  localparam logic [7:0] A_BASE  = 8'h00;
  localparam logic [7:0] A_ANA   = 8'h18;
  localparam logic [7:0] A_SYNC  = 8'h1c;
  localparam logic [7:0] A_NTSEL = 8'h20;
  localparam logic [7:0] A_STAT  = 8'h24;
  // Analog no-target choice
  typedef enum logic [1:0] {
    OTDU_NT_HOLD,
    OTDU_NT_LOW,
    OTDU_NT_HIGH
  } otdu_ntsel_t;
endpackage

// *** src/otdu_tmr_if.sv ***
// Interface between the unit and its delay timers
interface otdu_tmr_if;
  import otdu_pkg::*;
  logic             tick;  // 5 ms update pulse
  logic             trig;  // Trigger condition level
  logic [DLY_W-1:0] dly;   // Programmed delay in ticks
  logic             fire;  // Condition held full period
  modport ctl (output tick, trig, dly, input fire);
  modport tmr (input tick, trig, dly, output fire);
endinterface

// *** src/otdu_timer.sv ***
// Retriggerable delay timer counting 5 ms ticks
module otdu_timer
  import otdu_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Timer link
  otdu_tmr_if.tmr   t
);
  // Timer state
  typedef struct packed {
    logic [DLY_W-1:0] cnt;
    logic             fire;
  } otdu_tst_t;
  otdu_tst_t s_reg;
  otdu_tst_t s_next;

  // Count while trigger holds, clear on loss
  always_comb begin
    s_next = s_reg;
    if (!t.trig) begin
      s_next.cnt  = '0;
      s_next.fire = 1'b0;
    end else if (t.tick) begin
      // Zero delay fires on first update
      if (s_reg.cnt >= t.dly) begin
        s_next.fire = 1'b1;
      end else begin
        s_next.cnt  = s_reg.cnt + 1'b1;
        s_next.fire = (s_reg.cnt + 1'b1) >= {1'b0, t.dly};
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign t.fire = s_reg.fire;

  // Fire only while trigger held
  a_fire_needs_trig: assert property (
    @(posedge clk_sys) disable iff (rst)
    !t.trig |=> !t.fire)
    else $error("timer fired without trigger");
  // Zero delay fires after one tick
  a_zero_delay: assert property (
    @(posedge clk_sys) disable iff (rst)
    t.trig && t.tick && t.dly == '0 |=> t.fire)
    else $error("zero delay did not fire");
endmodule

// *** src/otdu_top.sv ***
// Output time delay unit with registers, divider and timers
module otdu_top
  import otdu_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // Measurement path conditions
  input  wire logic [NUM_SW-1:0] sw_want_on,
  input  wire logic              no_target,
  input  wire logic              sync_missing,
  // Outputs
  output logic      [NUM_SW-1:0] sw_state,
  output logic                   ana_override,
  output logic      [1:0]        cur_ntsel,
  output logic      [1:0]        volt_ntsel,
  output logic                   sync_lost
);
  // Unit state
  typedef struct packed {
    logic [DIV_W-1:0]        div;
    logic                    tick;
    logic [NUM_TMR-1:0][DLY_W-1:0] dly;
    logic [1:0]              cur_sel;
    logic [1:0]              volt_sel;
    logic [NUM_SW-1:0]       sw;
    logic [NUM_SW-1:0]       nt_lost;
    logic                    ana;
    logic                    sync;
    logic [31:0]             rdata;
  } otdu_st_t;
  otdu_st_t s_reg;
  otdu_st_t s_next;

  logic [NUM_TMR-1:0] trig;  // Trigger per timer
  logic [NUM_TMR-1:0] fire;  // Expiry per timer

  // Word address to timer slot
  function automatic logic [3:0] slot_of(input logic [7:0] a);
    slot_of = 4'(a[7:2]);
  endfunction

  // Timer trigger conditions
  always_comb begin
    trig = '0;
    for (int i = 0; i < NUM_SW; i++) begin
      // On trigger: switch off, measurement wants on, target present
      trig[3*i]   = sw_want_on[i] && !s_reg.sw[i] && !no_target;
      // Off trigger: switch on, measurement wants off, target present
      trig[3*i+1] = !sw_want_on[i] && s_reg.sw[i] && !no_target;
      // No-target trigger per switch
      trig[3*i+2] = no_target;
    end
    trig[T_ANA]  = no_target;
    trig[T_SYNC] = sync_missing;
  end

  // Timer instances
  genvar g;
  generate
    for (g = 0; g < NUM_TMR; g++) begin : g_tmr
      otdu_tmr_if ti ();
      assign ti.tick = s_reg.tick;
      assign ti.trig = trig[g];
      assign ti.dly  = s_reg.dly[g];
      assign fire[g] = ti.fire;
      otdu_timer u_tmr (
        .clk_sys (clk_sys),
        .rst     (rst),
        .t       (ti)
      );
    end
  endgenerate

  // Next state
  always_comb begin
    s_next = s_reg;
    // Tick divider
    if (s_reg.div >= DIV_W'(TICK_DIV - 1)) begin
      s_next.div  = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.div  = s_reg.div + 1'b1;
      s_next.tick = 1'b0;
    end
    // Switch actions on expiry
    for (int i = 0; i < NUM_SW; i++) begin
      if (fire[3*i]) begin
        s_next.sw[i] = 1'b1;
      end else if (fire[3*i+1]) begin
        s_next.sw[i] = 1'b0;
      end
      s_next.nt_lost[i] = fire[3*i+2];
    end
    // Analog override follows its timer
    s_next.ana  = fire[T_ANA];
    s_next.sync = fire[T_SYNC];
    // Register writes
    if (reg_wr) begin
      if (reg_addr < A_ANA + 8'h08) begin
        s_next.dly[slot_of(reg_addr)] = reg_wdata[DLY_W-1:0];
      end else if (reg_addr == A_NTSEL) begin
        s_next.cur_sel  = reg_wdata[1:0];
        s_next.volt_sel = reg_wdata[3:2];
      end
    end
    // Register reads, data next cycle
    s_next.rdata = '0;
    if (reg_rd) begin
      if (reg_addr < A_ANA + 8'h08) begin
        s_next.rdata = {16'h0000, s_reg.dly[slot_of(reg_addr)]};
      end else if (reg_addr == A_NTSEL) begin
        s_next.rdata = {28'h0000000, s_reg.volt_sel, s_reg.cur_sel};
      end else if (reg_addr == A_STAT) begin
        s_next.rdata = {24'h000000, 2'b00, s_reg.sync, s_reg.ana,
                        s_reg.nt_lost, s_reg.sw};
      end
    end
  end

  // State register with documented defaults
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_reg <= '0;
      for (int i = 0; i < NUM_SW; i++) begin
        s_reg.dly[3*i]   <= DEF_ONOFF;
        s_reg.dly[3*i+1] <= DEF_ONOFF;
        s_reg.dly[3*i+2] <= DEF_NT;
      end
      s_reg.dly[T_ANA]  <= DEF_ANA;
      s_reg.dly[T_SYNC] <= DEF_SYNC;
      s_reg.cur_sel     <= OTDU_NT_HOLD;
      s_reg.volt_sel    <= OTDU_NT_HOLD;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs
  assign reg_rdata    = s_reg.rdata;
  assign sw_state     = s_reg.sw;
  assign ana_override = s_reg.ana;
  assign cur_ntsel    = s_reg.cur_sel;
  assign volt_ntsel   = s_reg.volt_sel;
  assign sync_lost    = s_reg.sync;

  // Tick spacing
  sequence s_tick_gap;
    s_reg.tick ##1 !s_reg.tick;
  endsequence
  // Trigger loss reaches an output two edges later
  sequence s_ana_gone;
    ##1 !ana_override;
  endsequence
  sequence s_sync_gone;
    ##1 !sync_lost;
  endsequence
  sequence s_nt_gone;
    ##1 s_reg.nt_lost == '0;
  endsequence
  // Tick is one cycle wide
  a_tick_pulse: assert property (
    @(posedge clk_sys) disable iff (rst)
    s_reg.tick && TICK_DIV > 1 |-> s_tick_gap)
    else $error("tick not a single pulse");
  // Tick only at divider wrap
  a_tick_wrap: assert property (
    @(posedge clk_sys) disable iff (rst)
    s_reg.tick |-> s_reg.div == '0)
    else $error("tick away from divider wrap");
  // Divider never passes its period
  a_div_range: assert property (
    @(posedge clk_sys) disable iff (rst)
    s_reg.div < DIV_W'(TICK_DIV))
    else $error("divider out of range");
  // Target return clears analog override
  a_ana_clear: assert property (
    @(posedge clk_sys) disable iff (rst)
    !no_target |=> s_ana_gone)
    else $error("override stayed after target back");
  // Override only after no-target
  a_ana_needs_nt: assert property (
    @(posedge clk_sys) disable iff (rst)
    $rose(ana_override) |-> $past(no_target, 2))
    else $error("override without no-target");
  // Analog expiry drives the override
  a_ana_follow: assert property (
    @(posedge clk_sys) disable iff (rst)
    fire[T_ANA] |=> ana_override)
    else $error("override missed analog expiry");
  // Read data only in the read slot
  a_read_zero: assert property (
    @(posedge clk_sys) disable iff (rst)
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data outside read slot");
  // Delay read returns the stored word
  a_dly_read: assert property (
    @(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr < A_ANA + 8'h08 |=>
      reg_rdata == {16'h0000, $past(s_reg.dly[slot_of(reg_addr)])})
    else $error("delay read wrong");
  // Choice read returns both fields
  a_sel_read: assert property (
    @(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr == A_NTSEL |=>
      reg_rdata == {28'h0000000, $past(volt_ntsel), $past(cur_ntsel)})
    else $error("choice read wrong");
  // Status read returns output states
  a_stat_read: assert property (
    @(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr == A_STAT |=>
      reg_rdata[5:0] == {$past(sync_lost), $past(ana_override),
                         $past(s_reg.nt_lost), $past(sw_state)})
    else $error("status read wrong");
  // Status upper bits stay clear
  a_stat_upper: assert property (
    @(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr == A_STAT |=> reg_rdata[31:6] == '0)
    else $error("status upper bits set");
  // Unmapped reads return zero
  a_hole_read: assert property (
    @(posedge clk_sys) disable iff (rst)
    reg_rd && reg_addr > A_STAT |=> reg_rdata == 32'h00000000)
    else $error("unmapped read not zero");
  // Delay write lands in its slot
  a_dly_write: assert property (
    @(posedge clk_sys) disable iff (rst)
    reg_wr && reg_addr < A_ANA + 8'h08 |=>
      s_reg.dly[slot_of($past(reg_addr))] == $past(reg_wdata[DLY_W-1:0]))
    else $error("delay write lost");
  // Delays change only by a write
  a_dly_keep: assert property (
    @(posedge clk_sys) disable iff (rst)
    !reg_wr |=> $stable(s_reg.dly))
    else $error("delay changed without write");
  // Choice write stores both fields
  a_sel_write: assert property (
    @(posedge clk_sys) disable iff (rst)
    reg_wr && reg_addr == A_NTSEL |=>
      cur_ntsel == $past(reg_wdata[1:0]) &&
      volt_ntsel == $past(reg_wdata[3:2]))
    else $error("no-target choice not stored");
  // Choices hold between writes
  a_sel_keep: assert property (
    @(posedge clk_sys) disable iff (rst)
    !(reg_wr && reg_addr == A_NTSEL) |=>
      $stable(cur_ntsel) && $stable(volt_ntsel))
    else $error("choice changed without write");
  // Sync flag needs a missing sync
  a_sync_needs: assert property (
    @(posedge clk_sys) disable iff (rst)
    $rose(sync_lost) |-> $past(sync_missing, 2))
    else $error("sync lost without cause");
  // Sync return clears the flag
  a_sync_clear: assert property (
    @(posedge clk_sys) disable iff (rst)
    !sync_missing |=> s_sync_gone)
    else $error("sync flag stayed");
  // Sync expiry drives the flag
  a_sync_follow: assert property (
    @(posedge clk_sys) disable iff (rst)
    fire[T_SYNC] |=> sync_lost)
    else $error("sync flag missed expiry");
  // First switch turns on only with a cause
  a_sw_on_cause: assert property (
    @(posedge clk_sys) disable iff (rst)
    $rose(sw_state[0]) |-> $past(sw_want_on[0], 2))
    else $error("switch on without cause");
  // Second switch likewise
  a_sw1_on_cause: assert property (
    @(posedge clk_sys) disable iff (rst)
    $rose(sw_state[1]) |-> $past(sw_want_on[1], 2))
    else $error("second switch on without cause");
  // First switch turns off only with a cause
  a_sw_off_cause: assert property (
    @(posedge clk_sys) disable iff (rst)
    $fell(sw_state[0]) |-> !$past(sw_want_on[0], 2))
    else $error("switch off without cause");
  // Second switch likewise
  a_sw1_off_cause: assert property (
    @(posedge clk_sys) disable iff (rst)
    $fell(sw_state[1]) |-> !$past(sw_want_on[1], 2))
    else $error("second switch off without cause");
  // On expiry sets the first switch
  a_sw_on_act: assert property (
    @(posedge clk_sys) disable iff (rst)
    fire[0] |=> sw_state[0])
    else $error("switch missed on expiry");
  // On expiry sets the second switch
  a_sw1_on_act: assert property (
    @(posedge clk_sys) disable iff (rst)
    fire[3] |=> sw_state[1])
    else $error("second switch missed on expiry");
  // Off expiry clears the first switch
  a_sw_off_act: assert property (
    @(posedge clk_sys) disable iff (rst)
    fire[1] && !fire[0] |=> !sw_state[0])
    else $error("switch missed off expiry");
  // Off expiry clears the second switch
  a_sw1_off_act: assert property (
    @(posedge clk_sys) disable iff (rst)
    fire[4] && !fire[3] |=> !sw_state[1])
    else $error("second switch missed off expiry");
  // First switch holds without an expiry
  a_sw_hold: assert property (
    @(posedge clk_sys) disable iff (rst)
    !fire[0] && !fire[1] |=> $stable(sw_state[0]))
    else $error("switch moved without expiry");
  // Second switch holds without an expiry
  a_sw1_hold: assert property (
    @(posedge clk_sys) disable iff (rst)
    !fire[3] && !fire[4] |=> $stable(sw_state[1]))
    else $error("second switch moved without expiry");
  // Switch no-target flags need no-target
  a_nt_needs: assert property (
    @(posedge clk_sys) disable iff (rst)
    $rose(s_reg.nt_lost[0]) |-> $past(no_target, 2))
    else $error("no-target flag without cause");
  a_nt1_needs: assert property (
    @(posedge clk_sys) disable iff (rst)
    $rose(s_reg.nt_lost[1]) |-> $past(no_target, 2))
    else $error("second no-target flag without cause");
  // Target return clears switch flags
  a_nt_clear: assert property (
    @(posedge clk_sys) disable iff (rst)
    !no_target |=> s_nt_gone)
    else $error("no-target flag stayed");
  // Reset leaves outputs low
  a_reset_outs: assert property (
    @(posedge clk_sys)
    rst |=> sw_state == '0 && !ana_override && !sync_lost &&
      reg_rdata == 32'h00000000)
    else $error("outputs not cleared by reset");
  // Reset loads the default delays
  a_reset_dly: assert property (
    @(posedge clk_sys)
    rst |=> s_reg.dly[0] == DEF_ONOFF && s_reg.dly[1] == DEF_ONOFF &&
      s_reg.dly[T_ANA] == DEF_ANA && s_reg.dly[T_SYNC] == DEF_SYNC)
    else $error("default delays wrong");
  // No-target default after reset
  a_default_nt: assert property (
    @(posedge clk_sys)
    $fell(rst) |-> s_reg.dly[2] == DEF_NT)
    else $error("no-target default wrong");
endmodule

// *** verif/otdu_ctl_model.sv ***
// Controller model that reads the analog choice the unit presents
module otdu_ctl_model (
  // Clock
  input  wire logic       clk_sys,
  // Unit outputs
  input  wire logic       ana_override,
  input  wire logic [1:0] cur_ntsel,
  // Seen level, 3 means normal tracking
  output logic      [1:0] cur_view
);
  timeunit 1ns;
  timeprecision 1ps;
  // Latch what the loop would carry
  always_ff @(posedge clk_sys) begin
    cur_view <= ana_override ? cur_ntsel : 2'h3;
  end
endmodule

// *** verif/output_time_delay_unit_bench.sv ***
// Self-checking bench for the output time delay unit
module output_time_delay_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import otdu_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [NUM_SW-1:0] sw_want_on = '0;
  logic no_target = 1'b0;
  logic sync_missing = 1'b0;
  logic [NUM_SW-1:0] sw_state;
  logic ana_override, sync_lost, rd_d = 1'b0;
  logic [1:0] cur_ntsel, volt_ntsel, cur_view;
  logic [31:0] seed = 32'hbaad;
  logic [31:0] exp_q[$];
  int mismatches = 0;
  int checks_done = 0;
  // Half period of 2 ns
  always #2 clk_sys = ~clk_sys;
  otdu_top #(.TICK_DIV(4)) uut (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sw_want_on(sw_want_on),
    .no_target(no_target), .sync_missing(sync_missing),
    .sw_state(sw_state), .ana_override(ana_override),
    .cur_ntsel(cur_ntsel), .volt_ntsel(volt_ntsel),
    .sync_lost(sync_lost));
  otdu_ctl_model ctl (.clk_sys(clk_sys), .ana_override(ana_override),
    .cur_ntsel(cur_ntsel), .cur_view(cur_view));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    if (mismatches == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1; reg_addr <= a; exp_q.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Read data watcher, compares against oldest note
  always @(posedge clk_sys) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      if (exp_q.size() == 0) check(reg_rdata, 32'hdead);
      else check(reg_rdata, exp_q.pop_front());
    end
  end
  // Watchdog
  initial begin
    #12000;
    mismatches++;
    give_verdict();
  end
  // Main sequence
  initial begin
    idle(4);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++)
      rd(8'(i * 4), (i == 2 || i == 5) ? 32'h2ee0 : 32'h0);
    rd(8'h28, 32'h0);
    rd(A_STAT, 32'h0);
    repeat (4) begin
      seed = xs(seed);
      wr(A_SYNC, seed);
      rd(A_SYNC, {16'h0, seed[15:0]});
    end
    wr(A_SYNC, 32'h0);
    sync_missing <= 1'b1;
    idle(6);
    rd(A_STAT, 32'h20);
    check({31'h0, sync_lost}, 32'h1);
    sync_missing <= 1'b0;
    wr(8'h00, 32'h3);
    repeat (2) begin
      sw_want_on <= 2'b01; idle(6);
      sw_want_on <= 2'b00; idle(2);
    end
    rd(A_STAT, 32'h0);
    sw_want_on <= 2'b01;
    idle(6);
    rd(A_STAT, 32'h0);
    idle(30);
    rd(A_STAT, 32'h1);
    sw_want_on <= 2'b11;
    idle(4);
    rd(A_STAT, 32'h3);
    check({30'h0, sw_state}, 32'h3);
    sw_want_on <= 2'b00;
    idle(4);
    rd(A_STAT, 32'h0);
    wr(A_ANA, 32'h2);
    wr(A_NTSEL, 32'h6);
    rd(A_NTSEL, 32'h6);
    check({30'h0, cur_ntsel}, 32'h2);
    check({30'h0, volt_ntsel}, 32'h1);
    repeat (2) begin
      no_target <= 1'b1; idle(3);
      no_target <= 1'b0; idle(2);
    end
    rd(A_STAT, 32'h0);
    no_target <= 1'b1;
    idle(20);
    rd(A_STAT, 32'h10);
    check({30'h0, cur_view}, 32'h2);
    check({31'h0, ana_override}, 32'h1);
    no_target <= 1'b0;
    idle(6);
    rd(A_STAT, 32'h0);
    idle(4);
    check(32'(exp_q.size()), 32'h0);
    give_verdict();
  end
endmodule
